// ===== inc/msspi_pkg.sv
// shared constants and types of the multibuffered spi slave
package msspi_pkg;

	// ==========================================================
	// word and buffer shape
	localparam int DATA_W  = 16;
	localparam int ENTRIES = 8;
	localparam int GROUPS  = 2;
	localparam int MODE_W  = 3;

	// ==========================================================
	// buffer behaviour codes that suspend on an unread receive slot
	localparam logic [MODE_W-1:0] MODE_SUSPEND_A = 3'h6;
	localparam logic [MODE_W-1:0] MODE_SUSPEND_B = 3'h7;

	// ==========================================================
	// register bit positions carried as plain ports
	localparam int LOOP_INJECT_BIT = 16; // loopback_test_control
	localparam int ENABLE_BIT      = 24; // global_control_one
	localparam int DMA_ENABLE_BIT  = 16; // interrupt_reg_zero

	// lowest supported ratio of peripheral to link clock is 12
	localparam int LINK_RATIO_MIN  = 12;

	// ==========================================================
	// values after reset
	localparam logic RST_TX_FULL  = 1'b0;
	localparam logic RST_RX_EMPTY = 1'b1;
	localparam logic RST_FLOW_N   = 1'b1;

	// ==========================================================
	// sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_HALT
	} msspi_seq_t;

endpackage

// ===== hw/msspi_link.sv
// link side shifter, clocked by the serial link clock
`timescale 1ns/1ps

module msspi_link
	import msspi_pkg::*;
#(
	parameter int W = DATA_W
) (
	input  wire logic         serial_link_clock,
	input  wire logic         rst,
	input  wire logic         slave_select_pin_n,
	input  wire logic         slave_in_line,
	input  wire logic         pin_loopback_test,
	input  wire logic [W-1:0] tx_word,
	output logic              slave_out_line,
	output logic              bit_toggle,
	output logic [W-1:0]      rx_word
);

	localparam logic [$clog2(W)-1:0] LAST = ($clog2(W))'(W - 1);

	logic [$clog2(W)-1:0] tx_cnt;
	logic [W-1:0]         tx_sh;
	logic [$clog2(W)-1:0] rx_cnt;
	logic [W-1:0]         rx_sh;
	logic                 in_bit;

	// loopback feeds our own output back in place of the pin
	assign in_bit = pin_loopback_test ? slave_out_line : slave_in_line;

	// drive on the leading edge; first edge of a word loads the new word
	always_ff @(posedge serial_link_clock or posedge slave_select_pin_n) begin
		if (slave_select_pin_n) begin
			tx_cnt         <= '0;
			tx_sh          <= '0;
			slave_out_line <= 1'b0;
		end else if (tx_cnt == '0) begin
			slave_out_line <= tx_word[W-1];
			tx_sh          <= {tx_word[W-2:0], 1'b0};
			tx_cnt         <= ($clog2(W))'(1);
		end else begin
			slave_out_line <= tx_sh[W-1];
			tx_sh          <= {tx_sh[W-2:0], 1'b0};
			tx_cnt         <= (tx_cnt == LAST) ? '0 : tx_cnt + 1'b1;
		end
	end

	// sample on the trailing edge, latch the word after its last bit
	always_ff @(negedge serial_link_clock or posedge slave_select_pin_n) begin
		if (slave_select_pin_n) begin
			rx_cnt  <= '0;
			rx_sh   <= '0;
			rx_word <= '0;
		end else begin
			rx_sh  <= {rx_sh[W-2:0], in_bit};
			rx_cnt <= (rx_cnt == LAST) ? '0 : rx_cnt + 1'b1;
			if (rx_cnt == LAST)
				rx_word <= {rx_sh[W-2:0], in_bit};
		end
	end

	// one toggle per sampled bit, survives frame ends so no false edge
	always_ff @(negedge serial_link_clock or posedge rst) begin
		if (rst)
			bit_toggle <= 1'b0;
		else
			bit_toggle <= ~bit_toggle;
	end

endmodule

// ===== hw/msspi_slave.sv
// multibuffered spi slave: buffers, sequencer and link control
`timescale 1ns/1ps

module msspi_slave
	import msspi_pkg::*;
#(
	parameter int W = DATA_W,
	parameter int N = ENTRIES,
	parameter int G = GROUPS
) (
	input  wire logic                    mclk,
	input  wire logic                    rst,
	input  wire logic                    serial_link_clock,
	input  wire logic                    slave_select_pin_n,
	input  wire logic                    slave_in_line,
	output logic                         slave_out_line,
	output logic                         slave_out_enable,
	output logic                         flow_enable_pin_n,
	output logic                         chip_select_out_n,
	input  wire logic                    module_enable,
	input  wire logic                    dma_request_enable,
	input  wire logic                    pin_loopback_test,
	input  wire logic                    inject_length_error,
	input  wire logic [G-1:0]            group_trigger,
	input  wire logic [G-1:0][$clog2(N)-1:0] group_first,
	input  wire logic [G-1:0][$clog2(N)-1:0] group_last,
	input  wire logic                    tx_write,
	input  wire logic [$clog2(N)-1:0]    tx_addr,
	input  wire logic [W-1:0]            tx_wdata,
	input  wire logic                    tx_whold,
	input  wire logic [MODE_W-1:0]       tx_wmode,
	input  wire logic                    rx_read,
	input  wire logic [$clog2(N)-1:0]    rx_addr,
	output logic [W-1:0]                 rx_rdata,
	output logic                         rx_rempty,
	output logic                         rx_roverrun,
	input  wire logic                    length_error_clear,
	output logic                         length_error,
	output logic                         dma_request,
	output logic                         suspended,
	output logic                         busy
);

	localparam int AW = $clog2(N);
	localparam int GW = (G > 1) ? $clog2(G) : 1;
	localparam int BW = $clog2(W);
	localparam logic [BW-1:0] LAST_BIT = BW'(W - 1);

	// ==========================================================
	// state of the peripheral clock domain
	typedef struct packed {
		logic                        sel_s1;
		logic                        sel_s2;
		logic                        sel_d;
		logic                        tog_s1;
		logic                        tog_s2;
		logic                        tog_d;
		logic [BW-1:0]               bit_cnt;
		msspi_seq_t                  seq;
		logic [GW-1:0]               grp;
		logic [AW-1:0]               ptr;
		logic                        fetch;
		logic                        susp;
		logic [W-1:0]                tx_word;
		logic                        hold;
		logic [N-1:0][W-1:0]         tx_data;
		logic [N-1:0]                tx_hold;
		logic [N-1:0][MODE_W-1:0]    tx_mode;
		logic [N-1:0]                tx_full;
		logic [N-1:0][W-1:0]         rx_data;
		logic [N-1:0]                rx_empty;
		logic [N-1:0]                rx_ovr;
		logic [W-1:0]                rd_data;
		logic                        rd_empty;
		logic                        rd_ovr;
		logic                        lerr;
		logic                        dma;
		logic                        flow_n;
	} msspi_state_t;

	msspi_state_t s;
	msspi_state_t next_s;

	logic [W-1:0] link_rx_word;
	logic         link_toggle;

	// ==========================================================
	// link side shifter
	msspi_link #(
		.W(W)
	) u_link (
		.serial_link_clock  (serial_link_clock),
		.rst                (rst),
		.slave_select_pin_n (slave_select_pin_n),
		.slave_in_line      (slave_in_line),
		.pin_loopback_test  (pin_loopback_test),
		.tx_word            (s.tx_word),
		.slave_out_line     (slave_out_line),
		.bit_toggle         (link_toggle),
		.rx_word            (link_rx_word)
	);

	// ==========================================================
	// helpers

	// lowest index is the highest priority group
	function automatic logic [GW-1:0] pick_group(input logic [G-1:0] trig);
		logic [GW-1:0] g;
		g = '0;
		for (int i = G - 1; i >= 0; i--) begin
			if (trig[i])
				g = GW'(i);
		end
		return g;
	endfunction

	function automatic logic is_suspend_mode(input logic [MODE_W-1:0] m);
		return (m == MODE_SUSPEND_A) || (m == MODE_SUSPEND_B);
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic          bit_evt;
		logic          word_evt;
		logic          frame_end;
		logic          lerr_set;
		logic [GW-1:0] top;
		logic          preempt;
		bit_evt   = 1'b0;
		word_evt  = 1'b0;
		frame_end = 1'b0;
		lerr_set  = 1'b0;
		top       = '0;
		preempt   = 1'b0;
		next_s    = s;
		next_s.dma = 1'b0;

		// two-stage synchronisers, edges taken from the second stage
		next_s.sel_s1 = slave_select_pin_n;
		next_s.sel_s2 = s.sel_s1;
		next_s.sel_d  = s.sel_s2;
		next_s.tog_s1 = link_toggle;
		next_s.tog_s2 = s.tog_s1;
		next_s.tog_d  = s.tog_s2;
		bit_evt       = s.tog_s2 ^ s.tog_d;
		frame_end     = s.sel_s2 & ~s.sel_d;

		// count bits; a frame that ends mid word is a length error
		if (frame_end) begin
			next_s.bit_cnt = '0;
			lerr_set       = (s.bit_cnt != '0);
		end else if (bit_evt) begin
			if (s.bit_cnt == LAST_BIT) begin
				next_s.bit_cnt = '0;
				word_evt       = 1'b1;
			end else begin
				next_s.bit_cnt = s.bit_cnt + 1'b1;
			end
		end

		// host fills a transmit slot; hold bit is only stored
		if (tx_write) begin
			next_s.tx_data[tx_addr] = tx_wdata;
			next_s.tx_hold[tx_addr] = tx_whold;
			next_s.tx_mode[tx_addr] = tx_wmode;
			next_s.tx_full[tx_addr] = 1'b1;
		end

		// host read empties the slot regardless of sequencer fetch
		if (rx_read) begin
			next_s.rd_data           = s.rx_data[rx_addr];
			next_s.rd_empty          = s.rx_empty[rx_addr];
			next_s.rd_ovr            = s.rx_ovr[rx_addr];
			next_s.rx_empty[rx_addr] = 1'b1;
			next_s.rx_ovr[rx_addr]   = 1'b0;
		end

		// sequencer
		case (s.seq)
			SEQ_IDLE: begin
				next_s.tx_word = '0;
				next_s.flow_n  = 1'b1;
				next_s.susp    = 1'b0;
				if (module_enable && (group_trigger != '0)) begin
					top          = pick_group(group_trigger);
					next_s.seq   = SEQ_RUN;
					next_s.grp   = top;
					next_s.ptr   = group_first[top];
					next_s.fetch = 1'b1;
				end
			end
			SEQ_RUN: begin
				if (!module_enable) begin
					next_s.seq     = SEQ_IDLE;
					next_s.fetch   = 1'b0;
					next_s.tx_word = '0;
					next_s.flow_n  = 1'b1;
				end else begin
					// a finished word lands in the receive slot
					if (word_evt && !s.susp && !s.fetch) begin
						next_s.rx_data[s.ptr]  = link_rx_word;
						next_s.rx_empty[s.ptr] = 1'b0; // new data beats a same-cycle read
						if (!s.rx_empty[s.ptr] && !is_suspend_mode(s.tx_mode[s.ptr]))
							next_s.rx_ovr[s.ptr] = 1'b1;
						next_s.dma = dma_request_enable;
						if (pin_loopback_test && inject_length_error)
							lerr_set = 1'b1;
						next_s.ptr   = (s.ptr == group_last[s.grp]) ? group_first[s.grp] : s.ptr + 1'b1;
						next_s.fetch = 1'b1;
						if (!group_trigger[s.grp] && (s.ptr == group_last[s.grp]))
							next_s.seq = SEQ_IDLE;
					end
					// between words a higher group takes over at its first slot
					if (s.fetch && (group_trigger != '0)) begin
						top     = pick_group(group_trigger);
						preempt = (top < s.grp);
					end
					if (preempt) begin
						next_s.grp = top;
						next_s.ptr = group_first[top];
					end else if (s.fetch || s.susp) begin
						// suspend while the matching receive slot is unread
						if (is_suspend_mode(s.tx_mode[s.ptr]) && !s.rx_empty[s.ptr]) begin
							next_s.susp    = 1'b1;
							next_s.tx_word = '0;
							next_s.flow_n  = 1'b1;
						end else begin
							// empty transmit slot sends zeros
							next_s.tx_word       = s.tx_full[s.ptr] ? s.tx_data[s.ptr] : '0;
							next_s.hold          = s.tx_hold[s.ptr];
							next_s.tx_full[s.ptr] = tx_write && (tx_addr == s.ptr); // same-cycle host write wins
							next_s.susp          = 1'b0;
							next_s.fetch         = 1'b0;
							next_s.flow_n        = 1'b0;
						end
					end
					// length error stops the transfer, nothing is resent
					if (lerr_set) begin
						next_s.seq     = SEQ_HALT;
						next_s.tx_word = '0;
						next_s.flow_n  = 1'b1;
						next_s.fetch   = 1'b0;
					end
				end
			end
			SEQ_HALT: begin
				next_s.tx_word = '0;
				next_s.flow_n  = 1'b1;
				next_s.susp    = 1'b0;
				if (!module_enable)
					next_s.seq = SEQ_IDLE;
			end
			default: begin
				next_s.seq = SEQ_IDLE;
			end
		endcase

		// sticky error flag: a new error wins over the clear
		if (length_error_clear)
			next_s.lerr = 1'b0;
		if (lerr_set)
			next_s.lerr = 1'b1;
	end

	// ==========================================================
	// registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			s          <= '0;
			s.seq      <= SEQ_IDLE;
			s.tx_full  <= {N{RST_TX_FULL}};
			s.rx_empty <= {N{RST_RX_EMPTY}};
			s.rd_empty <= RST_RX_EMPTY;
			s.flow_n   <= RST_FLOW_N;
			s.sel_s1   <= 1'b1;
			s.sel_s2   <= 1'b1;
			s.sel_d    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// outputs
	assign slave_out_enable  = ~slave_select_pin_n & ~pin_loopback_test;
	assign flow_enable_pin_n = s.flow_n;
	assign chip_select_out_n = 1'b1; // select is not functional as slave
	assign rx_rdata          = s.rd_data;
	assign rx_rempty         = s.rd_empty;
	assign rx_roverrun       = s.rd_ovr;
	assign length_error      = s.lerr;
	assign dma_request       = s.dma;
	assign suspended         = s.susp;
	assign busy              = (s.seq != SEQ_IDLE);

endmodule

// ===== verif/msspi_checker.sv
// port assertions for the multibuffered spi slave
`timescale 1ns/1ps

module msspi_checker
	import msspi_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic module_enable,
	input  wire logic dma_request_enable,
	input  wire logic pin_loopback_test,
	input  wire logic slave_select_pin_n,
	input  wire logic slave_out_enable,
	input  wire logic chip_select_out_n,
	input  wire logic length_error_clear,
	input  wire logic length_error,
	input  wire logic dma_request,
	input  wire logic busy
);
	// ==========================================================
	// link pins
	chk_select_unused: assert property (@(posedge mclk) disable iff (rst) chip_select_out_n)
		else $error("chip select output went active");
	chk_out_drive: assert property (@(posedge mclk) disable iff (rst)
		slave_out_enable == (!slave_select_pin_n && !pin_loopback_test))
		else $error("output enable does not follow select");

	// ==========================================================
	// dma requests
	chk_dma_gated: assert property (@(posedge mclk) disable iff (rst)
		!dma_request_enable && !$past(dma_request_enable) |-> !dma_request)
		else $error("dma request while requests disabled");
	chk_dma_single: assert property (@(posedge mclk) disable iff (rst) dma_request |=> !dma_request)
		else $error("dma request longer than one cycle");
	chk_dma_disabled: assert property (@(posedge mclk) disable iff (rst)
		(!module_enable)[*8] |-> !dma_request)
		else $error("dma request from disabled module");

	// ==========================================================
	// sequencer and length error
	chk_idle_off: assert property (@(posedge mclk) disable iff (rst)
		!module_enable && $past(!module_enable) |-> !busy)
		else $error("sequencer active while disabled");
	chk_start_on: assert property (@(posedge mclk) disable iff (rst) $rose(busy) |-> $past(module_enable))
		else $error("sequencer started without enable");
	chk_err_sticky: assert property (@(posedge mclk) disable iff (rst)
		length_error && !length_error_clear |=> length_error)
		else $error("length error dropped without clear");
	chk_err_stop: assert property (@(posedge mclk) disable iff (rst) length_error[*3] |-> !dma_request)
		else $error("word stored after length error");
endmodule

bind msspi_slave msspi_checker chk_u (.mclk, .rst, .module_enable, .dma_request_enable, .pin_loopback_test,
	.slave_select_pin_n, .slave_out_enable, .chip_select_out_n, .length_error_clear, .length_error,
	.dma_request, .busy);

// ===== verif/msspi_master_model.sv
// behavioural spi master driving the slave link pins
`timescale 1ns/1ps

module msspi_master_model (
	output logic      serial_link_clock,
	output logic      slave_select_pin_n,
	output logic      slave_in_line,
	input  wire logic slave_out_line
);
	// link clock idles low and stands still between frames
	initial begin
		serial_link_clock = 1'b0;
		slave_select_pin_n = 1'b1;
		slave_in_line = 1'b0;
	end

	// hold the select pin without clocking
	task automatic hold_select(input logic v);
		slave_select_pin_n = v;
	endtask

	// frame of n bits, msb first, drive on rise, sample on fall
	task automatic xfer(input logic [15:0] d, input int n, output logic [15:0] got);
		got = 16'h0000;
		#1.3;
		slave_select_pin_n = 1'b0;
		#62.5;
		for (int i = 0; i < n; i++) begin
			serial_link_clock = 1'b1; // 125 ns period, well below mclk/12
			slave_in_line = d[15-i];
			#62.5;
			serial_link_clock = 1'b0;
			got = {got[14:0], slave_out_line};
			#62.5;
		end
		slave_select_pin_n = 1'b1;
		slave_in_line = ~slave_in_line; // released line shows no stale value
	endtask
endmodule

// ===== verif/msspi_slave_tb.sv
// self-checking bench for the multibuffered spi slave
`timescale 1ns/1ps

module msspi_slave_tb
	import msspi_pkg::*;
;
	logic            mclk, rst, serial_link_clock, slave_select_pin_n, slave_in_line, slave_out_line;
	logic            slave_out_enable, flow_enable_pin_n, chip_select_out_n, module_enable, dma_request_enable;
	logic            pin_loopback_test, inject_length_error, tx_write, tx_whold, rx_read, rx_rempty;
	logic            rx_roverrun, length_error_clear, length_error, dma_request, suspended, busy;
	logic [1:0]      group_trigger;
	logic [1:0][2:0] group_first, group_last;
	logic [2:0]      tx_addr, rx_addr, tx_wmode;
	logic [15:0]     tx_wdata, rx_rdata, g, d;
	logic            e, o;
	int              miscompares, compares, n, c0;
	int              dma_cnt = 0;

	msspi_slave dut_u (.mclk, .rst, .serial_link_clock, .slave_select_pin_n, .slave_in_line, .slave_out_line,
		.slave_out_enable, .flow_enable_pin_n, .chip_select_out_n, .module_enable, .dma_request_enable,
		.pin_loopback_test, .inject_length_error, .group_trigger, .group_first, .group_last, .tx_write,
		.tx_addr, .tx_wdata, .tx_whold, .tx_wmode, .rx_read, .rx_addr, .rx_rdata, .rx_rempty, .rx_roverrun,
		.length_error_clear, .length_error, .dma_request, .suspended, .busy);
	msspi_master_model m_u (.serial_link_clock, .slave_select_pin_n, .slave_in_line, .slave_out_line);

	// ==========================================================
	// clock and request counting
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		if (dma_request === 1'b1) dma_cnt <= dma_cnt + 1;
	end

	// ==========================================================
	// helpers
	task automatic test_done();
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check_that(input logic c, input string m);
		compares++;
		if (c !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic must_see(input logic c, input string m);
		check_that(c, m);
		if (c !== 1'b1) test_done();
	endtask
	task automatic tx_put(input logic [2:0] a, input logic [15:0] v, input logic [2:0] md);
		@(posedge mclk);
		tx_write <= 1'b1;
		tx_addr <= a;
		tx_wdata <= v;
		tx_whold <= 1'b1;
		tx_wmode <= md;
		@(posedge mclk);
		tx_write <= 1'b0;
	endtask
	task automatic rx_get(input logic [2:0] a);
		@(posedge mclk);
		rx_read <= 1'b1;
		rx_addr <= a;
		@(posedge mclk);
		rx_read <= 1'b0;
		@(negedge mclk);
		{d, e, o} = {rx_rdata, rx_rempty, rx_roverrun};
	endtask
	task automatic go(input logic [1:0] t, input logic dma);
		@(posedge mclk);
		dma_request_enable <= dma;
		module_enable <= 1'b1;
		group_trigger <= t;
	endtask
	task automatic off();
		@(posedge mclk);
		dma_request_enable <= 1'b0;
		group_trigger <= 2'b00;
		@(posedge mclk);
		module_enable <= 1'b0;
		repeat (3) @(negedge mclk);
		check_that(busy === 1'b0, "sequencer not idle");
	endtask

	// ==========================================================
	// scenarios
	task automatic t_stream();
		tx_put(3'h0, 16'ha5c3, 3'h0);
		tx_put(3'h1, 16'h3c96, 3'h0);
		go(2'b01, 1'b1);
		c0 = dma_cnt;
		for (n = 0; n < 50 && flow_enable_pin_n !== 1'b0; n++) @(negedge mclk);
		must_see(flow_enable_pin_n === 1'b0, "no word loaded");
		m_u.xfer(16'h1234, 16, g);
		check_that(g === 16'ha5c3, "first word out");
		m_u.xfer(16'hfedc, 16, g);
		check_that(g === 16'h3c96, "second word out");
		m_u.xfer(16'h0f0f, 16, g);
		repeat (10) @(negedge mclk);
		check_that(dma_cnt == c0 + 3, "dma request count");
		rx_get(3'h0);
		check_that({d, e, o} === {16'h0f0f, 2'b01}, "overrun slot");
		rx_get(3'h1);
		check_that({d, e, o} === {16'hfedc, 2'b00}, "second slot");
		rx_get(3'h1);
		check_that(e === 1'b1, "slot not emptied by read");
		off();
	endtask
	task automatic t_suspend(input logic [2:0] md);
		tx_put(3'h2, 16'h5aa5, md);
		go(2'b10, 1'b1);
		m_u.xfer(16'h1111, 16, g);
		for (n = 0; n < 50 && suspended !== 1'b1; n++) @(negedge mclk);
		must_see(suspended === 1'b1, "no suspend on unread slot");
		c0 = dma_cnt;
		m_u.xfer(16'h2222, 16, g);
		repeat (10) @(negedge mclk);
		check_that(dma_cnt == c0, "word taken while suspended");
		rx_get(3'h2);
		check_that({d, e} === {16'h1111, 1'b0}, "suspended slot");
		for (n = 0; n < 20 && suspended !== 1'b0; n++) @(negedge mclk);
		check_that(suspended === 1'b0, "suspend not released");
		off();
	endtask
	task automatic t_preempt();
		tx_put(3'h2, 16'h6b6b, 3'h0);
		tx_put(3'h0, 16'h9d9d, 3'h0);
		go(2'b10, 1'b0);
		for (n = 0; n < 50 && flow_enable_pin_n !== 1'b0; n++) @(negedge mclk);
		must_see(flow_enable_pin_n === 1'b0, "no low group word");
		@(posedge mclk);
		group_trigger <= 2'b11;
		rx_read <= 1'b1;
		rx_addr <= 3'h2;
		m_u.xfer(16'h4444, 16, g);
		check_that(g === 16'h6b6b, "low group word out");
		@(posedge mclk);
		rx_read <= 1'b0;
		@(negedge mclk);
		check_that({rx_rdata, rx_rempty, rx_roverrun} === {16'h4444, 2'b10}, "read during group fetch");
		m_u.xfer(16'h5555, 16, g);
		check_that(g === 16'h9d9d, "preempting group first slot");
		off();
	endtask
	task automatic t_lenerr();
		@(posedge mclk);
		pin_loopback_test <= 1'b1;
		inject_length_error <= 1'b1;
		go(2'b01, 1'b1);
		m_u.xfer(16'h0000, 16, g);
		for (n = 0; n < 50 && length_error !== 1'b1; n++) @(negedge mclk);
		must_see(length_error === 1'b1, "no injected error");
		@(posedge mclk);
		length_error_clear <= 1'b1;
		@(posedge mclk);
		length_error_clear <= 1'b0;
		c0 = dma_cnt;
		m_u.xfer(16'h0000, 16, g);
		repeat (10) @(negedge mclk);
		check_that({length_error, busy} === 2'b01, "transfer repeated");
		check_that(dma_cnt == c0, "word stored while halted");
		@(posedge mclk);
		dma_request_enable <= 1'b0;
		@(posedge mclk);
		module_enable <= 1'b0;
		repeat (3) @(negedge mclk);
		check_that(busy === 1'b0, "disable ignored");
		go(2'b01, 1'b0);
		for (n = 0; n < 10 && busy !== 1'b1; n++) @(negedge mclk);
		check_that(busy === 1'b1, "no restart");
		off();
		@(posedge mclk);
		pin_loopback_test <= 1'b0;
		inject_length_error <= 1'b0;
	endtask
	task automatic t_spurious();
		go(2'b00, 1'b1);
		m_u.hold_select(1'b0);
		repeat (4) @(posedge mclk);
		c0 = dma_cnt;
		module_enable <= 1'b0;
		repeat (20) @(negedge mclk);
		check_that(dma_cnt == c0, "spurious dma request");
		m_u.hold_select(1'b1);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{rst, module_enable, dma_request_enable, pin_loopback_test, inject_length_error} = 5'h10;
		{tx_write, tx_whold, rx_read, length_error_clear, group_trigger} = 6'h00;
		{tx_addr, rx_addr, tx_wmode, tx_wdata} = 25'h0000000;
		group_first = {3'h2, 3'h0};
		group_last = {3'h2, 3'h1};
		{miscompares, compares} = 0;
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		check_that({rx_rempty, flow_enable_pin_n, chip_select_out_n, dma_request, busy} === 5'h1c, "reset");
		t_stream();
		t_suspend(MODE_SUSPEND_A);
		t_suspend(MODE_SUSPEND_B);
		t_preempt();
		t_lenerr();
		t_spurious();
		test_done();
	end
endmodule
